//--- verilog/sre_map.svh
// Constants of the serial EEPROM engine and its host: codes, widths, timing.
// Assumes the two ends run one frame at a time on a single two-wire link.
//
// Notes on behaviour
// - Write control byte: code, block, low R/W
// - Byte after write control loads pointer
// - Stop after data starts busy, no acks
// - Up to 16 bytes buffered, committed at Stop
// - Writes increment only low four pointer bits
// - Beyond 16 bytes, buffer overwrites oldest first
// - Page write wraps inside its own page
// - Host keeps writes inside one page
// - Protect input high blocks every array write
// - Poll with write control, ack when idle
// - Read control byte has R/W set
// - Pointer rests at last address plus one
// - Current read: ack, one byte, release
// - Random read keeps pointer from aborted write
// - Host ack asks for the next byte
// - Pointer advances after every byte access
// - Only code 1010; block bits address MSBs
// - Host nack on read releases data line
`ifndef SRE_MAP_SVH
`define SRE_MAP_SVH

// ****************************************************
// Protocol fields
// ****************************************************
`define SRE_DEV_CODE  4'hA
`define SRE_LAST_BIT  4'h7
`define SRE_ACK_BIT   4'h8
`define SRE_PAGE_N    16
`define SRE_MEM_N     2048

// ****************************************************
// Timing
// ****************************************************
`define SRE_CLK_NS    50
`define SRE_TWR_NS    5000000
`define SRE_TWR_W     17
`define SRE_QTR_DIV   4

`endif

//--- verilog/sre_pkg.sv
// Types shared by both ends of the serial EEPROM link.
// Assumes sre_map.svh supplies the numeric constants.
package sre_pkg;

   // Device byte-level phase, one-hot
   typedef enum logic [4:0] {
      SRE_CTRL   = 5'h01,
      SRE_ADDR   = 5'h02,
      SRE_WDATA  = 5'h04,
      SRE_RDATA  = 5'h08,
      SRE_IGNORE = 5'h10
   } sre_lnk_e;

   // Host sequencer state, one-hot
   typedef enum logic [3:0] {
      SRE_IDLE  = 4'h1,
      SRE_START = 4'h2,
      SRE_XFER  = 4'h4,
      SRE_STOP  = 4'h8
   } sre_hst_e;

   // Host command codes
   typedef enum logic [1:0] {
      SRE_OP_WRITE = 2'h0,
      SRE_OP_READ  = 2'h1,
      SRE_OP_POLL  = 2'h2
   } sre_op_e;

endpackage : sre_pkg

//--- verilog/sre_if.sv
// Two-wire link between the host end and the EEPROM end.
// Assumes open-drain data: an enabled driver pulls to its output, else pull-up.
`timescale 1ns/10ps
interface sre_if;
   logic scl;
   logic sda;
   logic hstSdaOut;
   logic hstSdaOe;
   logic devSdaOut;
   logic devSdaOe;

   // Wired-AND with pull-up
   assign sda = (hstSdaOe ? hstSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);

   modport host (
      output scl,
      output hstSdaOut,
      output hstSdaOe,
      input  sda
   );

   modport device (
      input  scl,
      input  sda,
      output devSdaOut,
      output devSdaOe
   );
endinterface : sre_if

//--- verilog/sre_device.sv
// EEPROM end: bit engine on the link clock, array and write cycle on clk.
// Assumes the host keeps the bus idle a few clk cycles after each Stop.
`timescale 1ns/10ps
`include "sre_map.svh"
module sre_device #(
   parameter int unsigned TWR_CYC = `SRE_TWR_NS / `SRE_CLK_NS
) (
   // System
   input wire logic clk,
   input wire logic nrst,
   // Write protect pin
   input wire logic wp,
   // Link
   sre_if.device    lnk
);

   // ****************************************************
   // Declarations
   // ****************************************************
   logic              startTgl_r;
   logic              stopTgl_r;
   logic              startSeen_r;
   logic [3:0]        bitCnt_r;
   logic [7:0]        shift_r;
   logic [7:0]        txByte_r;
   sre_pkg::sre_lnk_e st_r;
   logic [10:0]       ptr_r;
   logic              ackNow_r;
   logic              wrPend_r;
   logic [15:0]       pageVld_r;
   logic [7:0]        pageBuf [`SRE_PAGE_N];
   logic [2:0]        bsySync_r;
   logic              busyLnk_r;
   logic              sdaOe_r;
   logic              sdaOut_r;
   logic [2:0]        stopSync_r;
   logic              stopSeen_r;
   logic [2:0]        wpSync_r;
   logic              wpLvl_r;
   logic              busy_r;
   logic [`SRE_TWR_W-1:0] twrCnt_r;
   logic [7:0]        mem [`SRE_MEM_N];
   logic              newStart;
   logic [7:0]        rxByte;
   logic              stopEv;
   logic              commit;

   assign newStart = startTgl_r ^ startSeen_r;
   assign rxByte   = {shift_r[6:0], lnk.sda};

   // ****************************************************
   // Start and Stop detection on data-line edges
   // ****************************************************
   // Data falls while clock high
   always_ff @(negedge lnk.sda or negedge nrst) begin
      if (!nrst) begin
         startTgl_r <= 1'b0;
      end else if (lnk.scl) begin
         startTgl_r <= ~startTgl_r;
      end
   end

   // Data rises while clock high
   always_ff @(posedge lnk.sda or negedge nrst) begin
      if (!nrst) begin
         stopTgl_r <= 1'b0;
      end else if (lnk.scl) begin
         stopTgl_r <= ~stopTgl_r;
      end
   end

   // ****************************************************
   // Link clock domain: byte engine
   // ****************************************************
   // Busy level from clk; control byte gives eight edges to settle
   always_ff @(posedge lnk.scl or negedge nrst) begin
      if (!nrst) begin
         bsySync_r <= 3'h0;
         busyLnk_r <= 1'b0;
      end else begin
         bsySync_r <= {bsySync_r[1:0], busy_r};
         if (bsySync_r[1] == bsySync_r[2]) begin
            busyLnk_r <= bsySync_r[2];
         end
      end
   end

   // Shift, decode, ack decision and address pointer
   always_ff @(posedge lnk.scl or negedge nrst) begin
      if (!nrst) begin
         startSeen_r <= 1'b0;
         bitCnt_r    <= 4'h0;
         shift_r     <= 8'h00;
         txByte_r    <= 8'h00;
         st_r        <= sre_pkg::SRE_IGNORE;
         ptr_r       <= 11'h000;
         ackNow_r    <= 1'b0;
         wrPend_r    <= 1'b0;
         pageVld_r   <= 16'h0000;
      end else if (newStart) begin
         startSeen_r <= startTgl_r;
         shift_r     <= {7'h00, lnk.sda};
         bitCnt_r    <= 4'h1;
         st_r        <= sre_pkg::SRE_CTRL;
         ackNow_r    <= 1'b0;
         wrPend_r    <= 1'b0;
         pageVld_r   <= 16'h0000;
      end else if (bitCnt_r == `SRE_ACK_BIT) begin
         bitCnt_r <= 4'h0;
         ackNow_r <= 1'b0;
         // Own ack after the read control byte must not count as a host ack
         if (st_r == sre_pkg::SRE_RDATA && !ackNow_r) begin
            if (!lnk.sda) begin
               txByte_r <= mem[ptr_r];
               ptr_r    <= ptr_r + 11'h001;
            end else begin
               st_r <= sre_pkg::SRE_IGNORE;
            end
         end
      end else begin
         shift_r  <= rxByte;
         bitCnt_r <= bitCnt_r + 4'h1;
         if (bitCnt_r == `SRE_LAST_BIT) begin
            case (st_r)
               sre_pkg::SRE_CTRL: begin
                  // Wrong code or busy: stay silent till next Start
                  if (rxByte[7:4] != `SRE_DEV_CODE || busyLnk_r) begin
                     st_r <= sre_pkg::SRE_IGNORE;
                  end else if (rxByte[0]) begin
                     ackNow_r <= 1'b1;
                     st_r     <= sre_pkg::SRE_RDATA;
                     txByte_r <= mem[{rxByte[3:1], ptr_r[7:0]}];
                     ptr_r    <= {rxByte[3:1], ptr_r[7:0]} + 11'h001;
                  end else begin
                     ackNow_r     <= 1'b1;
                     st_r         <= sre_pkg::SRE_ADDR;
                     ptr_r[10:8]  <= rxByte[3:1];
                  end
               end
               sre_pkg::SRE_ADDR: begin
                  ackNow_r    <= 1'b1;
                  ptr_r[7:0]  <= rxByte;
                  st_r        <= sre_pkg::SRE_WDATA;
               end
               sre_pkg::SRE_WDATA: begin
                  // Acked even when protected; commit side decides
                  ackNow_r              <= 1'b1;
                  wrPend_r              <= 1'b1;
                  pageVld_r[ptr_r[3:0]] <= 1'b1;
                  ptr_r <= {ptr_r[10:4], ptr_r[3:0] + 4'h1};
               end
               default: begin
                  ackNow_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Page buffer; index is the low pointer, so overflow overwrites oldest
   always_ff @(posedge lnk.scl) begin
      if (!newStart && bitCnt_r == `SRE_LAST_BIT && st_r == sre_pkg::SRE_WDATA) begin
         pageBuf[ptr_r[3:0]] <= rxByte;
      end
   end

   // Data line changes only while clock low
   always_ff @(negedge lnk.scl or negedge nrst) begin
      if (!nrst) begin
         sdaOe_r   <= 1'b0;
         sdaOut_r  <= 1'b0;
      end else if (bitCnt_r == `SRE_ACK_BIT) begin
         sdaOe_r <= ackNow_r;
      end else if (st_r == sre_pkg::SRE_RDATA && !newStart) begin
         sdaOe_r <= ~txByte_r[~bitCnt_r[2:0]];
      end else begin
         sdaOe_r <= 1'b0;
      end
   end

   assign lnk.devSdaOe  = sdaOe_r;
   assign lnk.devSdaOut = sdaOut_r;

   // ****************************************************
   // System clock domain: Stop crossing, protect pin, write cycle
   // ****************************************************
   assign stopEv = (stopSync_r[1] == stopSync_r[2]) && (stopSync_r[2] != stopSeen_r);
   // Buffer, pointer and pending flag are quiet after Stop
   assign commit = stopEv && wrPend_r && !wpLvl_r && !busy_r;

   // Three-stage samplers for the Stop toggle and protect pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stopSync_r <= 3'h0;
         stopSeen_r <= 1'b0;
         wpSync_r   <= 3'h0;
         wpLvl_r    <= 1'b1;
      end else begin
         stopSync_r <= {stopSync_r[1:0], stopTgl_r};
         wpSync_r   <= {wpSync_r[1:0], wp};
         if (stopSync_r[1] == stopSync_r[2]) begin
            stopSeen_r <= stopSync_r[2];
         end
         if (wpSync_r[1] == wpSync_r[2]) begin
            wpLvl_r <= wpSync_r[2];
         end
      end
   end

   // Self-timed write cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_r   <= 1'b0;
         twrCnt_r <= '0;
      end else if (commit) begin
         busy_r   <= 1'b1;
         twrCnt_r <= `SRE_TWR_W'(TWR_CYC - 1);
      end else if (busy_r) begin
         if (twrCnt_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            twrCnt_r <= twrCnt_r - `SRE_TWR_W'(1);
         end
      end
   end

   // Array update: only bytes received this frame, all in one page
   always_ff @(posedge clk) begin
      if (commit) begin
         for (int i = 0; i < `SRE_PAGE_N; i++) begin
            if (pageVld_r[i]) begin
               mem[{ptr_r[10:4], 4'(i)}] <= pageBuf[i];
            end
         end
      end
   end

endmodule : sre_device

//--- verilog/sre_host.sv
// Host end: makes the link clock by division and runs one command per frame.
// Assumes the user holds a command until ready and reads nothing else.
`timescale 1ns/10ps
`include "sre_map.svh"
module sre_host #(
   parameter int unsigned QTR_DIV = `SRE_QTR_DIV
) (
   // System
   input  wire logic        clk,
   input  wire logic        nrst,
   // Command
   input  wire logic        cmdValid,
   input  wire logic [1:0]  cmdOp,
   input  wire logic [10:0] cmdAddr,
   input  wire logic [7:0]  cmdData,
   input  wire logic [3:0]  cmdCount,
   output logic             cmdReady,
   // Result
   output logic             donePulse,
   output logic             ackOk,
   output logic [7:0]       rdData,
   output logic             rdValid,
   // Link
   sre_if.host              lnk
);

   sre_pkg::sre_hst_e st_r;
   logic [1:0]  op_r;
   logic [10:0] addr_r;
   logic [7:0]  data_r;
   logic [3:0]  cnt_r;
   logic [2:0]  step_r;
   logic [15:0] div_r;
   logic [1:0]  qPh_r;
   logic [3:0]  bit_r;
   logic [7:0]  tx_r;
   logic [7:0]  rx_r;
   logic        rxMode_r;
   logic        ackSmp_r;
   logic        scl_r;
   logic        sdaOe_r;
   logic        sdaOut_r;
   logic [2:0]  sdaSync_r;
   logic        sdaLvl_r;
   logic        tick;

   assign tick = (div_r == 16'(QTR_DIV - 1));

   // Byte sent at each step of a frame
   function automatic logic [7:0] byteFor(input logic [2:0] s, input logic [1:0] op,
                                          input logic [10:0] a, input logic [7:0] d);
      if (s == 3'h0) begin
         byteFor = {`SRE_DEV_CODE, a[10:8], 1'b0};
      end else if (s == 3'h1) begin
         byteFor = a[7:0];
      end else if (op == sre_pkg::SRE_OP_WRITE) begin
         byteFor = d;
      end else begin
         byteFor = {`SRE_DEV_CODE, a[10:8], 1'b1};
      end
   endfunction : byteFor

   // Data pin through three stages
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sdaSync_r <= 3'h7;
         sdaLvl_r  <= 1'b1;
      end else begin
         sdaSync_r <= {sdaSync_r[1:0], lnk.sda};
         if (sdaSync_r[1] == sdaSync_r[2]) begin
            sdaLvl_r <= sdaSync_r[2];
         end
      end
   end

   // Quarter-period divider
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_r <= 16'h0000;
      end else if (st_r == sre_pkg::SRE_IDLE || tick) begin
         div_r <= 16'h0000;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end

   // Frame sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= sre_pkg::SRE_IDLE;
         op_r <= 2'h0;
         addr_r <= 11'h000;
         data_r <= 8'h00;
         cnt_r <= 4'h0;
         step_r <= 3'h0;
         qPh_r <= 2'h0;
         bit_r <= 4'h0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         rxMode_r <= 1'b0;
         ackSmp_r <= 1'b1;
         scl_r <= 1'b1;
         sdaOe_r <= 1'b0;
         sdaOut_r <= 1'b0;
         cmdReady <= 1'b1;
         donePulse <= 1'b0;
         ackOk <= 1'b0;
         rdData <= 8'h00;
         rdValid <= 1'b0;
      end else begin
         donePulse <= 1'b0;
         rdValid   <= 1'b0;
         case (st_r)
            sre_pkg::SRE_IDLE: begin
               if (cmdValid) begin
                  op_r <= cmdOp;
                  addr_r <= cmdAddr;
                  data_r <= cmdData;
                  cnt_r <= cmdCount;
                  step_r <= 3'h0;
                  qPh_r <= 2'h0;
                  rxMode_r <= 1'b0;
                  tx_r <= byteFor(3'h0, cmdOp, cmdAddr, cmdData);
                  ackOk <= 1'b1;
                  cmdReady <= 1'b0;
                  st_r <= sre_pkg::SRE_START;
               end
            end
            sre_pkg::SRE_START: begin
               if (tick) begin
                  qPh_r <= qPh_r + 2'h1;
                  case (qPh_r)
                     2'h0: scl_r <= 1'b1;
                     2'h1: sdaOe_r <= 1'b1;        // Data falls, clock high
                     2'h2: scl_r <= 1'b0;
                     default: begin
                        st_r    <= sre_pkg::SRE_XFER;
                        bit_r   <= 4'h0;
                        sdaOe_r <= ~tx_r[7];
                     end
                  endcase
               end
            end
            sre_pkg::SRE_XFER: begin
               if (tick) begin
                  qPh_r <= qPh_r + 2'h1;
                  case (qPh_r)
                     2'h0: scl_r <= 1'b1;
                     2'h1: scl_r <= 1'b1;
                     2'h2: begin
                        scl_r <= 1'b0;
                        if (bit_r == `SRE_ACK_BIT) begin
                           ackSmp_r <= sdaLvl_r;
                        end else begin
                           rx_r <= {rx_r[6:0], sdaLvl_r};
                        end
                     end
                     default: begin
                        if (bit_r != `SRE_ACK_BIT) begin
                           bit_r <= bit_r + 4'h1;
                           if (bit_r == `SRE_LAST_BIT) begin
                              sdaOe_r <= rxMode_r && (cnt_r != 4'h0);
                           end else begin
                              sdaOe_r <= !rxMode_r && !tx_r[~(bit_r[2:0] + 3'h1)];
                           end
                        end else if (!rxMode_r && ackSmp_r) begin
                           ackOk   <= 1'b0;        // Refused, close frame
                           sdaOe_r <= 1'b1;
                           st_r    <= sre_pkg::SRE_STOP;
                        end else if (rxMode_r) begin
                           rdData  <= rx_r;
                           rdValid <= 1'b1;
                           if (cnt_r == 4'h0) begin
                              sdaOe_r <= 1'b1;
                              st_r    <= sre_pkg::SRE_STOP;
                           end else begin
                              cnt_r   <= cnt_r - 4'h1;
                              bit_r   <= 4'h0;
                              sdaOe_r <= 1'b0;
                           end
                        end else if (op_r == sre_pkg::SRE_OP_POLL ||
                                     (op_r == sre_pkg::SRE_OP_WRITE && step_r == 3'h2)) begin
                           sdaOe_r <= 1'b1;
                           st_r    <= sre_pkg::SRE_STOP;
                        end else if (op_r == sre_pkg::SRE_OP_READ && step_r == 3'h1) begin
                           step_r  <= 3'h2;
                           tx_r    <= byteFor(3'h2, op_r, addr_r, data_r);
                           sdaOe_r <= 1'b0;
                           st_r    <= sre_pkg::SRE_START;
                        end else if (op_r == sre_pkg::SRE_OP_READ && step_r == 3'h2) begin
                           step_r   <= 3'h3;
                           rxMode_r <= 1'b1;
                           bit_r    <= 4'h0;
                           sdaOe_r  <= 1'b0;
                        end else begin
                           step_r  <= step_r + 3'h1;
                           tx_r    <= byteFor(step_r + 3'h1, op_r, addr_r, data_r);
                           bit_r   <= 4'h0;
                           sdaOe_r <= 1'(~byteFor(step_r + 3'h1, op_r, addr_r, data_r) >> 7);
                        end
                     end
                  endcase
               end
            end
            sre_pkg::SRE_STOP: begin
               if (tick) begin
                  qPh_r <= qPh_r + 2'h1;
                  case (qPh_r)
                     2'h0: scl_r <= 1'b1;
                     2'h1: sdaOe_r <= 1'b0;        // Data rises, clock high
                     2'h2: sdaOe_r <= 1'b0;
                     default: begin
                        donePulse <= 1'b1;
                        cmdReady  <= 1'b1;
                        st_r      <= sre_pkg::SRE_IDLE;
                     end
                  endcase
               end
            end
            default: st_r <= sre_pkg::SRE_IDLE;
         endcase
      end
   end

   assign lnk.scl       = scl_r;
   assign lnk.hstSdaOe  = sdaOe_r;
   assign lnk.hstSdaOut = sdaOut_r;

endmodule : sre_host

//--- tb/sre_link_sva.sv
// Checker of the two-wire link between host end and device end.
// Assumes scl is made from clk, so clk samples every wire change.
`timescale 1ns/10ps
module sre_link_sva #(
   parameter int unsigned QTR_DIV = 4
) (
   // System
   input wire logic clk,
   input wire logic nrst,
   // Link wires
   input wire logic scl,
   input wire logic sda,
   input wire logic hstSdaOut,
   input wire logic hstSdaOe,
   input wire logic devSdaOut,
   input wire logic devSdaOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [9:0] devOn_r;
   // ****************
   // Pull length
   // ****************
   // A stuck device pull would hang the bus for every later frame
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) devOn_r <= 10'h000;
      else if (devSdaOe) devOn_r <= devOn_r + 10'h001;
      else devOn_r <= 10'h000;
   end
   property p_open_drain;
      !hstSdaOut && !devSdaOut;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("driver not open drain");
   property p_dev_scl_low;
      $changed(devSdaOe) |-> !scl;
   endproperty
   a_dev_scl_low: assert property (p_dev_scl_low) else $error("device moved sda, scl high");
   property p_no_fight;
      // Both pulling low while clock is low is legal open-drain overlap
      !(hstSdaOe && devSdaOe && scl);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends pull sda");
   property p_start_host;
      $fell(sda) && scl && $past(scl) |-> hstSdaOe && !devSdaOe;
   endproperty
   a_start_host: assert property (p_start_host) else $error("start not by host");
   property p_stop_host;
      $rose(sda) && scl && $past(scl) |-> $fell(hstSdaOe) && !devSdaOe;
   endproperty
   a_stop_host: assert property (p_stop_host) else $error("stop not by host");
   property p_scl_high;
      $rose(scl) |-> scl[*8];
   endproperty
   a_scl_high: assert property (p_scl_high) else $error("scl high too short");
   property p_ack_hold;
      $rose(scl) && devSdaOe |-> devSdaOe[*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("device bit not held");
   property p_pull_max;
      devOn_r <= 10'(36 * QTR_DIV);
   endproperty
   a_pull_max: assert property (p_pull_max) else $error("device pull too long");
   // Main scenarios seen
   c_ack: cover property ($rose(devSdaOe));
   c_start: cover property ($fell(sda) && scl);
   c_rel: cover property ($fell(devSdaOe) && !hstSdaOe);
endmodule : sre_link_sva

//--- tb/tb_serial_eeprom_rw_engine.sv
// Bench: host end and device end joined by the link, run from the command port.
// Assumes clk at 20 MHz and a write cycle shortened by parameter.
`timescale 1ns/10ps
module tb_serial_eeprom_rw_engine;
   logic        clk;
   logic        nrst;
   logic        wp;
   logic        cmdValid;
   logic [1:0]  cmdOp;
   logic [10:0] cmdAddr;
   logic [7:0]  cmdData;
   logic [3:0]  cmdCount;
   logic        cmdReady;
   logic        donePulse;
   logic        ackOk;
   logic [7:0]  rdData;
   logic        rdValid;
   logic [7:0]  got[$];
   int          nFail;
   int          checksDone;
   sre_if       lnkIf();
   sre_host #(.QTR_DIV(4)) sre_host_i (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
      .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdCount(cmdCount),
      .cmdReady(cmdReady), .donePulse(donePulse), .ackOk(ackOk), .rdData(rdData),
      .rdValid(rdValid), .lnk(lnkIf));
   sre_device #(.TWR_CYC(400)) sre_device_i (.clk(clk), .nrst(nrst), .wp(wp), .lnk(lnkIf));
   sre_link_sva #(.QTR_DIV(4)) sre_link_sva_i (.clk(clk), .nrst(nrst), .scl(lnkIf.scl),
      .sda(lnkIf.sda), .hstSdaOut(lnkIf.hstSdaOut), .hstSdaOe(lnkIf.hstSdaOe),
      .devSdaOut(lnkIf.devSdaOut), .devSdaOe(lnkIf.devSdaOe));
   // ****************
   // Tasks
   // ****************
   task automatic testDone();
      if (nFail == 0 && checksDone > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : testDone
   task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] seen);
      checksDone++;
      if (seen !== expv) begin
         nFail++;
         $display("unexpected %s: expected %h seen %h", what, expv, seen);
      end
   endtask : chk
   // One frame; idle gap first, since the device commits just after a Stop
   task automatic runCmd(input logic [1:0] op, input logic [10:0] a, input logic [7:0] d,
                         input logic [3:0] n);
      int i;
      got.delete();
      repeat (8) @(negedge clk);
      for (i = 0; i < 9000 && cmdReady !== 1'b1; i++) @(negedge clk);
      cmdOp = op;
      cmdAddr = a;
      cmdData = d;
      cmdCount = n;
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
      for (i = 0; i < 9000 && donePulse !== 1'b1; i++) begin
         @(negedge clk);
         if (rdValid === 1'b1) got.push_back(rdData);
      end
      if (donePulse !== 1'b1) begin
         chk("frame end", 8'h01, 8'h00);
         testDone();
      end
   endtask : runCmd
   // Write one byte, then poll until the device answers again
   task automatic wrByte(input logic [10:0] a, input logic [7:0] d, input logic busy);
      int np;
      runCmd(sre_pkg::SRE_OP_WRITE, a, d, 4'h0);
      chk("write ack", 8'h01, {7'h00, ackOk});
      for (np = 1; np < 12; np++) begin
         runCmd(sre_pkg::SRE_OP_POLL, a, 8'h00, 4'h0);
         if (ackOk === 1'b1) break;
      end
      chk("poll ack", 8'h01, {7'h00, ackOk});
      chk("write busy", {7'h00, busy}, {7'h00, np > 1});
   endtask : wrByte
   // Random read of two bytes in address order
   task automatic rdTwo(input logic [10:0] a, input logic [7:0] e0, input logic [7:0] e1);
      runCmd(sre_pkg::SRE_OP_READ, a, 8'h00, 4'h1);
      chk("read count", 8'h02, 8'(got.size()));
      chk("read first", e0, got[0]);
      chk("read next", e1, got[1]);
   endtask : rdTwo
   // ****************
   // Sequence
   // ****************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      nFail = 0;
      checksDone = 0;
      nrst = 1'b0;
      wp = 1'b0;
      cmdValid = 1'b0;
      cmdOp = 2'h0;
      cmdAddr = 11'h000;
      cmdData = 8'h00;
      cmdCount = 4'h0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      wrByte(11'h123, 8'h5A, 1'b1);
      wrByte(11'h124, 8'hC3, 1'b1);
      wrByte(11'h1FF, 8'h11, 1'b1);
      wrByte(11'h200, 8'h22, 1'b1);
      rdTwo(11'h123, 8'h5A, 8'hC3);
      rdTwo(11'h1FF, 8'h11, 8'h22);
      // Protected write: acked, no write cycle, array unchanged
      wp = 1'b1;
      wrByte(11'h123, 8'h99, 1'b0);
      rdTwo(11'h123, 8'h5A, 8'hC3);
      testDone();
   end
endmodule : tb_serial_eeprom_rw_engine
